// ==== tb/dmacp_channel_assertions.sv ====
// port checker for the block-copy channel: memory port and register bus timing
// bound to dmacp_channel; one clock, synchronous active-low reset
`timescale 1ns/1ps
module dmacp_channel_assertions (
   input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
   input wire logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
   input wire logic        s_axi_rvalid, mem_req, mem_we, mem_ack, bus_own,
   input wire logic [1:0]  s_axi_bresp, mem_size,
   input wire logic [31:0] mem_addr, mem_wdata, mem_rdata
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [31:0] rd_q, rd_d, wr_q, wr_d;
   logic        hr_q, hr_d, hw_q, hw_d;
   // last item addresses, forgotten once the bus is given up so runs never chain
   always_comb begin
      rd_d = rd_q;
      wr_d = wr_q;
      hr_d = hr_q & bus_own;
      hw_d = hw_q & bus_own;
      if (mem_req && mem_ack) begin
         if (mem_we) begin
            wr_d = mem_addr;
            hw_d = 1'b1;
         end else begin
            rd_d = mem_addr;
            hr_d = 1'b1;
         end
      end
   end
   always_ff @(posedge aclk) begin
      rd_q <= rd_d;
      wr_q <= wr_d;
      if (!aresetn) begin
         hr_q <= 1'b0;
         hw_q <= 1'b0;
      end else begin
         hr_q <= hr_d;
         hw_q <= hw_d;
      end
   end
   sequence s_rd_ack;
      mem_req && !mem_we && mem_ack;
   endsequence
   sequence s_next_rd;
      $rose(mem_req) && !mem_we && hr_q;
   endsequence
   sequence s_next_wr;
      $rose(mem_we) && mem_req && hw_q;
   endsequence
   a_req_stands: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
      else $error("request moved before ack");
   a_write_copies: assert property (s_rd_ack |=> mem_req && mem_we && mem_wdata[15:0] == $past(mem_rdata[15:0]))
      else $error("written item differs");
   a_req_owns: assert property (mem_req |-> bus_own)
      else $error("access without bus ownership");
   a_dst_steps: assert property (s_next_wr |-> mem_addr == wr_q + (32'h0000_0001 << mem_size))
      else $error("destination step wrong");
   a_src_steps: assert property (s_next_rd |-> mem_addr == rd_q + (32'h0000_0001 << mem_size))
      else $error("source step wrong");
   a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("response dropped early");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("late read data");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
      |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("late write response");
endmodule
bind dmacp_channel dmacp_channel_assertions u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .mem_req, .mem_we, .mem_ack, .bus_own, .s_axi_bresp, .mem_size, .mem_addr, .mem_wdata, .mem_rdata);

// ==== tb/dmacp_mem_model.sv ====
// memory model for the channel's far side: source rom and target ram
// answers each request with a one-cycle ack after ack_delay waiting cycles
`timescale 1ns/1ps
module dmacp_mem_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   input  wire logic [3:0]  ack_delay,
   output logic             mem_ack,
   output logic [31:0]      mem_rdata
);
   logic [15:0] wmem [0:63];
   logic [3:0]  wait_q;
   logic        gap_q;
   int          wr_count;
   // read data is the inverted low half of the address with the upper half zero, and toggles whenever no request is answered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mem_ack   <= 1'b0;
         gap_q     <= 1'b0;
         wait_q    <= 4'h0;
         wr_count  <= 0;
         mem_rdata <= 32'h0000_0000;
      end else if (mem_ack || gap_q || !mem_req) begin
         // a dead cycle after each ack so a stale request is never answered twice
         mem_ack   <= 1'b0;
         gap_q     <= mem_ack;
         mem_rdata <= ~mem_rdata;
      end else if (wait_q != ack_delay) begin
         wait_q    <= wait_q + 4'h1;
         mem_rdata <= ~mem_rdata;
      end else begin
         mem_ack   <= 1'b1;
         wait_q    <= 4'h0;
         mem_rdata <= {16'h0000, ~mem_addr[15:0]};
         if (mem_we) begin
            wmem[mem_addr[6:1]] <= mem_wdata[15:0];
            wr_count            <= wr_count + 1;
         end
      end
   end
endmodule

// ==== tb/test_dma_channel_block_copy.sv ====
// self-checking bench for the block-copy channel over its register bus
// uses dmacp_mem_model as memory; single 25 MHz clock
`timescale 1ns/1ps
module test_dma_channel_block_copy;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, mem_req, mem_we;
   logic        mem_ack, nmi_event, bus_own, irq;
   logic [1:0]  s_axi_bresp, s_axi_rresp, mem_size, rr;
   logic [3:0]  s_axi_wstrb, ack_delay;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, mem_addr, mem_wdata, mem_rdata;
   logic [31:0] rd, ea, sa, da, n, base;
   int          fails, samples_checked, k, i;
   dmacp_channel DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_req,
      .mem_we, .mem_addr, .mem_size, .mem_wdata, .mem_ack, .mem_rdata, .nmi_event, .bus_own, .irq);
   dmacp_mem_model u_mem (.aclk, .aresetn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .ack_delay,
      .mem_ack, .mem_rdata);
   // clock
   always #20 aclk = ~aclk;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // readies are looked at mid-cycle, so the edge that follows is the handshake edge
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er = dmacp_pkg::RESP_OKAY);
      logic       ah, wh, bh;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      bh = 1'b0;
      while (!bh) begin
         @(negedge aclk);
         {ah, wh, bh, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
         @(posedge aclk);
         if (ah) s_axi_awvalid <= 1'b0;
         if (wh) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      chk(32'(r), 32'(er));
   endtask
   task automatic rd_raw(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ah, rh;
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      rh = 1'b0;
      while (!rh) begin
         @(negedge aclk);
         {ah, rh, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
         @(posedge aclk);
         if (ah) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
   endtask
   task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er = dmacp_pkg::RESP_OKAY);
      logic [31:0] d;
      logic [1:0]  r;
      rd_raw(a, d, r);
      chk(d, e);
      chk(32'(r), 32'(er));
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // watchdog: the whole sequence needs well under 50000 cycles
   initial begin
      #2000000;
      fails++;
      finish_test;
   end
   // main sequence: reset values, gating, two copies (prompt and slow memory), nmi flag
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, nmi_event} = 6'h00;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      s_axi_wstrb = 4'hf;
      ack_delay = 4'h0;
      fails = 0;
      samples_checked = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rdchk(dmacp_pkg::ADDR_STANDBY, 32'h0000_0001);
      rdchk(dmacp_pkg::ADDR_CTRL, 32'h0000_0000);
      rdchk(dmacp_pkg::ADDR_OPER, 32'h0000_0000);
      rdchk(32'hfffe_1100, 32'h0000_0000, dmacp_pkg::RESP_SLVERR);
      wr(32'hfffe_1100, 32'h0000_0001, dmacp_pkg::RESP_SLVERR);
      for (k = 0; k < 2; k++) begin
         ack_delay <= k ? 4'h3 : 4'h0;
         sa = k ? 32'h0000_1200 : 32'h0000_1000;
         da = k ? 32'hfff8_1040 : 32'hfff8_1000;
         n = k ? 32'h0000_0007 : 32'h0000_0004;
         base = u_mem.wr_count;
         wr(dmacp_pkg::ADDR_CTRL, 32'h0000_0000);
         wr(dmacp_pkg::ADDR_SRC, sa);
         wr(dmacp_pkg::ADDR_DST, da);
         wr(dmacp_pkg::ADDR_COUNT, n);
         wr(dmacp_pkg::ADDR_CTRL, 32'h8000_5428);
         wr(dmacp_pkg::ADDR_IRQ_ENABLE, k ? 32'h0000_0000 : 32'h0000_0007);
         if (k == 0) begin
            wr(dmacp_pkg::ADDR_OPER, 32'h0000_0001);
            wr(dmacp_pkg::ADDR_CTRL, 32'h8000_5429);
            repeat (40) @(posedge aclk);
            rdchk(dmacp_pkg::ADDR_COUNT, n);
            wr(dmacp_pkg::ADDR_OPER, 32'h0000_0000);
            wr(dmacp_pkg::ADDR_STANDBY, 32'h0000_0000);
            repeat (40) @(posedge aclk);
            chk(u_mem.wr_count, base);
            wr(dmacp_pkg::ADDR_OPER, 32'h0000_0001);
         end else begin
            wr(dmacp_pkg::ADDR_CTRL, 32'h8000_5429);
         end
         rd = 32'h0000_0000;
         i = 0;
         while (!rd[1] && i < 200) begin
            rd_raw(dmacp_pkg::ADDR_CTRL, rd, rr);
            i++;
         end
         chk(32'(rd[1]), 32'h0000_0001);
         chk(u_mem.wr_count - base, n);
         rdchk(dmacp_pkg::ADDR_COUNT, 32'h0000_0000);
         rdchk(dmacp_pkg::ADDR_SRC, sa + (n << 1));
         rdchk(dmacp_pkg::ADDR_DST, da + (n << 1));
         for (i = 0; i < n; i++) begin
            rd = da + 32'(i << 1);
            ea = sa + 32'(i << 1);
            chk({16'h0000, u_mem.wmem[rd[6:1]]}, {16'h0000, ~ea[15:0]});
         end
         repeat (2) @(posedge aclk);
         chk(32'(irq), k ? 32'h0000_0000 : 32'h0000_0001);
         rdchk(dmacp_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
         wr(dmacp_pkg::ADDR_IRQ_CLEAR, 32'h0000_0001);
         repeat (2) @(posedge aclk);
         chk(32'(irq), 32'h0000_0000);
         wr(dmacp_pkg::ADDR_CTRL, 32'h8000_5428);
         rdchk(dmacp_pkg::ADDR_CTRL, 32'h8000_5428);
      end
      @(posedge aclk);
      nmi_event <= 1'b1;
      @(posedge aclk);
      nmi_event <= 1'b0;
      rdchk(dmacp_pkg::ADDR_OPER, 32'h0000_0003);
      wr(dmacp_pkg::ADDR_OPER, 32'h0000_0001);
      rdchk(dmacp_pkg::ADDR_OPER, 32'h0000_0001);
      finish_test;
   end
endmodule

// ==== verilog/dmacp_channel.sv ====
// one channel of the memory access controller with its AXI4-Lite register file
// assumes a single clock, a synchronous memory port with ack, and software setup
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
module dmacp_channel #(
   parameter int CW = 32
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             mem_req,
   output logic             mem_we,
   output logic [31:0]      mem_addr,
   output logic [1:0]       mem_size,
   output logic [31:0]      mem_wdata,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata,
   input  wire logic        nmi_event,
   output logic             bus_own,
   output logic             irq
);

   initial begin
      if (CW < 2 || CW > 32) $error("dmacp_channel: count width must be 2..32");
   end

   // byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction

   // an address that does not suit the item size is an address error
   function automatic logic misaligned(input logic [31:0] a, input logic [1:0] ts);
      logic m;
      m = 1'b0;
      if (ts == dmacp_pkg::TS_WORD) m = a[0];
      else if (ts == dmacp_pkg::TS_LONG) m = |a[1:0];
      else if (ts != dmacp_pkg::TS_BYTE) m = 1'b1;
      return m;
   endfunction

   // next address for one mode field
   function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] mode, input logic [31:0] sz);
      logic [31:0] r;
      r = a;
      if (mode == dmacp_pkg::AMODE_INC) r = a + sz;
      else if (mode == dmacp_pkg::AMODE_DEC) r = a - sz;
      return r;
   endfunction

   // register and bus state
   logic [7:0]    stby_q, stby_d;
   logic [31:0]   src_q, src_d, dst_q, dst_d, ctrl_q, ctrl_d;
   logic [CW-1:0] count_q, count_d;
   logic [15:0]   oper_q, oper_d;
   logic [dmacp_pkg::IRQ_W-1:0] ist_q, ist_d, ien_q, ien_d;
   logic          aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [31:0]   awaddr_q, awaddr_d, wdata_q, wdata_d, rdata_q, rdata_d;
   logic [3:0]    wstrb_q, wstrb_d;
   logic [1:0]    bresp_q, bresp_d, rresp_q, rresp_d;
   dmacp_pkg::dmacp_ch_state_t state_q, state_d;

   logic          do_write, mv_start, mv_done, run, te_set, ae_set, nmi_set;
   logic [31:0]   item_size;
   logic [CW-1:0] count_dec;

   assign s_axi_awready = !aw_have_q;
   assign s_axi_wready  = !w_have_q;
   assign s_axi_arready = !rvalid_q;
   assign do_write      = aw_have_q && w_have_q && !bvalid_q;

   // field views
   logic          f_enable, f_count_mode, f_bus_mode;
   logic [1:0]    f_dm, f_sm, f_ts;
   logic [3:0]    f_rs;
   assign f_enable     = ctrl_q[dmacp_pkg::CTRL_ENABLE];
   assign f_count_mode = ctrl_q[dmacp_pkg::CTRL_COUNT_MODE];
   assign f_bus_mode   = ctrl_q[dmacp_pkg::CTRL_BUS_MODE];
   assign f_dm         = ctrl_q[dmacp_pkg::CTRL_DM_LSB +: 2];
   assign f_sm         = ctrl_q[dmacp_pkg::CTRL_SM_LSB +: 2];
   assign f_rs         = ctrl_q[dmacp_pkg::CTRL_RS_LSB +: 4];
   assign f_ts         = ctrl_q[dmacp_pkg::CTRL_TS_LSB +: 2];
   assign item_size    = 32'h0000_0001 << f_ts;
   assign count_dec    = count_q - {{(CW-1){1'b0}}, 1'b1};

   // a pending error flag or finished copy also holds the channel off
   assign run = !stby_q[dmacp_pkg::STBY_MSTOP_BIT]
                && oper_q[dmacp_pkg::OPER_DME]
                && f_enable
                && !oper_q[dmacp_pkg::OPER_AE]
                && !oper_q[dmacp_pkg::OPER_NONMASKABLE_INTERRUPT_FLAG]
                && !ctrl_q[dmacp_pkg::CTRL_TE];

   // channel sequencer
   always_comb begin
      state_d  = state_q;
      mv_start = 1'b0;
      te_set   = 1'b0;
      ae_set   = 1'b0;
      case (state_q)
         dmacp_pkg::CH_IDLE: begin
            if (run && f_rs == dmacp_pkg::RS_AUTO) begin
               if (misaligned(src_q, f_ts) || misaligned(dst_q, f_ts)) begin
                  ae_set = 1'b1;
               end else begin
                  mv_start = 1'b1;
                  state_d  = dmacp_pkg::CH_MOVE;
               end
            end
         end
         dmacp_pkg::CH_MOVE: begin
            if (mv_done) begin
               if (count_dec == '0) begin
                  te_set  = 1'b1;
                  state_d = dmacp_pkg::CH_IDLE;
               end else if (!run) begin
                  state_d = dmacp_pkg::CH_IDLE;
               end else if (f_bus_mode && f_count_mode) begin
                  mv_start = 1'b1;
               end else begin
                  state_d = dmacp_pkg::CH_WAIT; // bus released between items
               end
            end
         end
         dmacp_pkg::CH_WAIT: state_d = dmacp_pkg::CH_IDLE;
         default: state_d = dmacp_pkg::CH_IDLE;
      endcase
   end

   assign nmi_set = nmi_event;

   // register file next values
   always_comb begin
      stby_d    = stby_q;
      src_d     = src_q;
      dst_d     = dst_q;
      count_d   = count_q;
      ctrl_d    = ctrl_q;
      oper_d    = oper_q;
      ist_d     = ist_q;
      ien_d     = ien_q;
      aw_have_d = aw_have_q;
      w_have_d  = w_have_q;
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;

      // address and data are latched separately, in either order
      if (s_axi_awvalid && !aw_have_q) begin
         aw_have_d = 1'b1;
         awaddr_d  = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_q) begin
         w_have_d = 1'b1;
         wdata_d  = s_axi_wdata;
         wstrb_d  = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) bvalid_d = 1'b0;

      // software writes
      if (do_write) begin
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = dmacp_pkg::RESP_OKAY;
         if (awaddr_q == dmacp_pkg::ADDR_STANDBY) begin
            stby_d = 8'(merge(32'(stby_q), wdata_q, wstrb_q));
         end else if (awaddr_q == dmacp_pkg::ADDR_SRC) begin
            src_d = merge(src_q, wdata_q, wstrb_q);
         end else if (awaddr_q == dmacp_pkg::ADDR_DST) begin
            dst_d = merge(dst_q, wdata_q, wstrb_q);
         end else if (awaddr_q == dmacp_pkg::ADDR_COUNT) begin
            count_d = CW'(merge(32'(count_q), wdata_q, wstrb_q));
         end else if (awaddr_q == dmacp_pkg::ADDR_CTRL) begin
            // transfer end only clears on a written 0, never sets from software
            ctrl_d = merge(ctrl_q, wdata_q, wstrb_q) & dmacp_pkg::CTRL_WMASK;
            ctrl_d[dmacp_pkg::CTRL_TE] = ctrl_q[dmacp_pkg::CTRL_TE] & (wdata_q[1] | !wstrb_q[0]);
         end else if (awaddr_q == dmacp_pkg::ADDR_OPER) begin
            // enable takes the new bit; the two flags can only be cleared
            oper_d[2:0] = 3'(merge(32'(oper_q), wdata_q, wstrb_q)) & {oper_q[2:1], 1'b1};
         end else if (awaddr_q == dmacp_pkg::ADDR_IRQ_CLEAR) begin
            if (wstrb_q[0]) ist_d = ist_q & ~wdata_q[dmacp_pkg::IRQ_W-1:0];
         end else if (awaddr_q == dmacp_pkg::ADDR_IRQ_ENABLE) begin
            if (wstrb_q[0]) ien_d = wdata_q[dmacp_pkg::IRQ_W-1:0];
         end else if (awaddr_q != dmacp_pkg::ADDR_IRQ_STATUS) begin
            bresp_d = dmacp_pkg::RESP_SLVERR;
         end
      end

      // channel progress; a count of zero runs the whole count range
      if (mv_done) begin
         src_d   = step_addr(src_q, f_sm, item_size);
         dst_d   = step_addr(dst_q, f_dm, item_size);
         count_d = count_dec;
      end

      // hardware sets win over a clearing write in the same cycle
      if (te_set) ctrl_d[dmacp_pkg::CTRL_TE] = 1'b1;
      if (ae_set) oper_d[dmacp_pkg::OPER_AE] = 1'b1;
      if (nmi_set) oper_d[dmacp_pkg::OPER_NONMASKABLE_INTERRUPT_FLAG] = 1'b1;
      ist_d = ist_d | {nmi_set, ae_set, te_set};

      // reads
      if (s_axi_rvalid && s_axi_rready) rvalid_d = 1'b0;
      if (s_axi_arvalid && !rvalid_q) begin
         rvalid_d = 1'b1;
         rresp_d  = dmacp_pkg::RESP_OKAY;
         rdata_d  = 32'h0000_0000;
         if (s_axi_araddr == dmacp_pkg::ADDR_STANDBY) rdata_d = 32'(stby_q);
         else if (s_axi_araddr == dmacp_pkg::ADDR_SRC) rdata_d = src_q;
         else if (s_axi_araddr == dmacp_pkg::ADDR_DST) rdata_d = dst_q;
         else if (s_axi_araddr == dmacp_pkg::ADDR_COUNT) rdata_d = 32'(count_q);
         else if (s_axi_araddr == dmacp_pkg::ADDR_CTRL) rdata_d = ctrl_q;
         else if (s_axi_araddr == dmacp_pkg::ADDR_OPER) rdata_d = 32'(oper_q);
         else if (s_axi_araddr == dmacp_pkg::ADDR_IRQ_STATUS) rdata_d = 32'(ist_q);
         else if (s_axi_araddr == dmacp_pkg::ADDR_IRQ_ENABLE) rdata_d = 32'(ien_q);
         else if (s_axi_araddr != dmacp_pkg::ADDR_IRQ_CLEAR) rresp_d = dmacp_pkg::RESP_SLVERR;
      end
   end

   // register everything
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q   <= dmacp_pkg::CH_IDLE;
         stby_q    <= dmacp_pkg::STBY_RESET;
         src_q     <= 32'h0000_0000;
         dst_q     <= 32'h0000_0000;
         count_q   <= '0;
         ctrl_q    <= dmacp_pkg::CTRL_RESET;
         oper_q    <= dmacp_pkg::OPER_RESET;
         ist_q     <= '0;
         ien_q     <= '0;
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= 32'h0000_0000;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= dmacp_pkg::RESP_OKAY;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= dmacp_pkg::RESP_OKAY;
      end else begin
         state_q   <= state_d;
         stby_q    <= stby_d;
         src_q     <= src_d;
         dst_q     <= dst_d;
         count_q   <= count_d;
         ctrl_q    <= ctrl_d;
         oper_q    <= oper_d;
         ist_q     <= ist_d;
         ien_q     <= ien_d;
         aw_have_q <= aw_have_d;
         w_have_q  <= w_have_d;
         awaddr_q  <= awaddr_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;
   assign bus_own      = (state_q == dmacp_pkg::CH_MOVE);
   assign irq          = |(ist_q & ien_q);

   // the item mover owns the memory port
   dmacp_mover #(
      .AW (32),
      .DW (32)
   ) u_mover (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .start     (mv_start),
      .src_addr  (mv_done ? src_d : src_q), // chained item uses stepped address
      .dst_addr  (mv_done ? dst_d : dst_q),
      .size      (f_ts),
      .done      (mv_done),
      .mem_req   (mem_req),
      .mem_we    (mem_we),
      .mem_addr  (mem_addr),
      .mem_size  (mem_size),
      .mem_wdata (mem_wdata),
      .mem_ack   (mem_ack),
      .mem_rdata (mem_rdata)
   );

endmodule

// ==== verilog/dmacp_mover.sv ====
// single-item mover: one read from the source, one write to the destination
// assumes a memory port that answers each request with a one-cycle ack
`timescale 1ns/1ps
module dmacp_mover #(
   parameter int AW = 32,
   parameter int DW = 32
) (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          start,
   input  wire logic [AW-1:0] src_addr,
   input  wire logic [AW-1:0] dst_addr,
   input  wire logic [1:0]    size,
   output logic               done,
   output logic               mem_req,
   output logic               mem_we,
   output logic [AW-1:0]      mem_addr,
   output logic [1:0]         mem_size,
   output logic [DW-1:0]      mem_wdata,
   input  wire logic          mem_ack,
   input  wire logic [DW-1:0] mem_rdata
);

   initial begin
      if (AW < 2 || DW != 32) $error("dmacp_mover: unsupported widths");
   end

   dmacp_pkg::dmacp_mv_state_t state_q, state_d;
   logic [AW-1:0] dst_q, dst_d, addr_q, addr_d;
   logic [DW-1:0] data_q, data_d;
   logic [1:0]    size_q, size_d;
   logic          done_q, done_d;

   // read then write; the write goes straight to memory, never through a cache
   always_comb begin
      state_d = state_q;
      dst_d   = dst_q;
      addr_d  = addr_q;
      data_d  = data_q;
      size_d  = size_q;
      done_d  = 1'b0;
      case (state_q)
         dmacp_pkg::MV_IDLE: begin
            if (start) begin
               addr_d  = src_addr;
               dst_d   = dst_addr;
               size_d  = size;
               state_d = dmacp_pkg::MV_READ;
            end
         end
         dmacp_pkg::MV_READ: begin
            if (mem_ack) begin
               data_d  = mem_rdata;
               addr_d  = dst_q;
               state_d = dmacp_pkg::MV_WRITE;
            end
         end
         dmacp_pkg::MV_WRITE: begin
            if (mem_ack) begin
               done_d  = 1'b1;
               state_d = dmacp_pkg::MV_IDLE;
            end
         end
         default: state_d = dmacp_pkg::MV_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= dmacp_pkg::MV_IDLE;
         dst_q   <= '0;
         addr_q  <= '0;
         data_q  <= '0;
         size_q  <= 2'b00;
         done_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         dst_q   <= dst_d;
         addr_q  <= addr_d;
         data_q  <= data_d;
         size_q  <= size_d;
         done_q  <= done_d;
      end
   end

   assign done      = done_q;
   assign mem_req   = (state_q != dmacp_pkg::MV_IDLE);
   assign mem_we    = (state_q == dmacp_pkg::MV_WRITE);
   assign mem_addr  = addr_q;
   assign mem_size  = size_q;
   assign mem_wdata = data_q;

endmodule

// ==== verilog/dmacp_pkg.sv ====
// package for the block-copy channel of the memory access controller
// assumes a 32-bit AXI4-Lite register bus and one 32-bit memory port
package dmacp_pkg;

   // register byte addresses
   localparam logic [31:0] ADDR_STANDBY     = 32'hfffe_0018;
   localparam logic [31:0] ADDR_SRC         = 32'hfffe_1000;
   localparam logic [31:0] ADDR_DST         = 32'hfffe_1004;
   localparam logic [31:0] ADDR_COUNT       = 32'hfffe_1008;
   localparam logic [31:0] ADDR_CTRL        = 32'hfffe_100c;
   localparam logic [31:0] ADDR_OPER        = 32'hfffe_1200;
   localparam logic [31:0] ADDR_IRQ_STATUS  = 32'hfffe_1210;
   localparam logic [31:0] ADDR_IRQ_CLEAR   = 32'hfffe_1214;
   localparam logic [31:0] ADDR_IRQ_ENABLE  = 32'hfffe_1218;

   // standby control, module stop set at reset so the controller sleeps
   localparam int          STBY_MSTOP_BIT   = 0;
   localparam logic [7:0]  STBY_RESET       = 8'h01;

   // channel control fields
   localparam int          CTRL_COUNT_MODE  = 31;
   localparam int          CTRL_DM_LSB      = 14;
   localparam int          CTRL_SM_LSB      = 12;
   localparam int          CTRL_RS_LSB      = 8;
   localparam int          CTRL_BUS_MODE    = 5;
   localparam int          CTRL_TS_LSB      = 3;
   localparam int          CTRL_TE          = 1;
   localparam int          CTRL_ENABLE      = 0;
   localparam logic [31:0] CTRL_WMASK       = 32'h8000_ff3d;
   localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;

   // field codes
   localparam logic [1:0]  AMODE_FIXED      = 2'b00;
   localparam logic [1:0]  AMODE_INC        = 2'b01;
   localparam logic [1:0]  AMODE_DEC        = 2'b10;
   localparam logic [3:0]  RS_AUTO          = 4'b0100;
   localparam logic [1:0]  TS_BYTE          = 2'b00;
   localparam logic [1:0]  TS_WORD          = 2'b01;
   localparam logic [1:0]  TS_LONG          = 2'b10;

   // operation register fields
   localparam int          OPER_AE          = 2;
   localparam int          OPER_NONMASKABLE_INTERRUPT_FLAG        = 1;
   localparam int          OPER_DME         = 0;
   localparam logic [15:0] OPER_RESET       = 16'h0000;

   // interrupt status layout
   localparam int          IRQ_W            = 3;
   localparam int          IRQ_END          = 0;
   localparam int          IRQ_ADDR_ERR     = 1;
   localparam int          IRQ_NMI          = 2;

   // axi responses
   localparam logic [1:0]  RESP_OKAY        = 2'b00;
   localparam logic [1:0]  RESP_SLVERR      = 2'b10;

   typedef enum logic [2:0] {
      CH_IDLE  = 3'b001,
      CH_MOVE  = 3'b010,
      CH_WAIT  = 3'b100
   } dmacp_ch_state_t;

   typedef enum logic [2:0] {
      MV_IDLE  = 3'b001,
      MV_READ  = 3'b010,
      MV_WRITE = 3'b100
   } dmacp_mv_state_t;

endpackage
